// ===== inc/sst_pkg.sv
// package: register map, field positions and types of the serial core
package sst_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int         ADDR_W      = 3;
	localparam logic [2:0] ADDR_CTRL1  = 3'h0;
	localparam logic [2:0] ADDR_CTRL2  = 3'h1;
	localparam logic [2:0] ADDR_SYNC   = 3'h2;
	localparam logic [2:0] ADDR_DATA   = 3'h3;
	localparam logic [2:0] ADDR_STATUS = 3'h4;

	// ****************************************
	// control 1 fields and reset value
	// ****************************************
	localparam int         C1_RX_HOLD   = 0;
	localparam int         C1_TX_HOLD   = 1;
	localparam int         C1_STRIP     = 2;
	localparam int         C1_CLR_SYNC  = 3;
	localparam int         C1_TX_IRQ_EN = 4;
	localparam int         C1_RX_IRQ_EN = 5;
	localparam logic [7:0] CTRL1_RST    = 8'h03;

	// ****************************************
	// control 2 fields and reset value
	// ****************************************
	localparam int         C2_TWO_BYTE  = 0;
	localparam int         C2_ERR_IRQ   = 1;
	localparam int         C2_SYNC_UNDF = 2;
	localparam int         C2_MODE_LO   = 3;
	localparam logic [7:0] CTRL2_RST    = 8'h00;
	localparam logic [7:0] SYNC_RST     = 8'h00;
	localparam logic [7:0] FILL_ONES    = 8'hFF;
	localparam logic [7:0] RX_IDLE      = 8'hFF;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		SST_SYNC_ONE = 2'h0,
		SST_SYNC_TWO = 2'h1,
		SST_SYNC_EXT = 2'h2
	} sst_mode_e;

	typedef struct packed {
		logic [1:0] zero;
		logic       irqActive;
		logic       synced;
		logic       carrier;
		logic       overrun;
		logic       txSpace;
		logic       rxReady;
	} sst_status_s;

endpackage : sst_pkg

// ===== hdl/sst_core.sv
// synchronous serial transmit and receive core with register port
//
// Behaviour
// - three-byte transmit fifo, space flag with enable
// - transmit fifo advances on bus clock falls
// - one-byte and two-byte transfer modes
// - next character loads during last bit
// - transmit clock shifts, least significant first
// - underflow sends ones or sync code
// - start on first full high, falling edge
// - hold flushes fifo, space flag inhibited
// - receive shifter reads all ones in reset
// - external mode syncs on carrier input
// - single sync match per bit, then held
// - two sync needs next whole character match
// - sync codes before sync never stored
// - strip sync drops sync-code characters
// - sync kept until clear, receiver hold or external-mode carrier loss, clear inhibits search
// - characters enter fifo, move to furthest
// - ready flag per transfer mode occupancy
// - ready with enable raises low interrupt
// - fifo read clears ready, refills later
// - full input location sets overrun, overwrites
// - overrun clears after status then data read
// - external reset sets holds, clears enables
//
// The placing of the registers and the strobed register port were left to the implementer.
module sst_core #(
	parameter int CHAR_BITS = 8,
	parameter int DEPTH     = 3
) (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic [sst_pkg::ADDR_W-1:0] busAddr,
	input  wire logic [7:0]               busWrData,
	input  wire logic                     busWrStb,
	input  wire logic                     busRdStb,
	output logic      [7:0]               busRdData,
	input  wire logic                     busPhaseClock,
	input  wire logic                     txClk,
	input  wire logic                     rxClk,
	input  wire logic                     rxSerial,
	input  wire logic                     carrierSyncInput,
	output logic                          txSerial,
	output logic                          irqOut,
	output logic                          irqOe
);

	// ****************************************
	// input synchronisers and edge detection
	// ****************************************
	logic [4:0] syncA_reg, syncB_reg, syncC_reg;
	logic [4:0] syncA_next, syncB_next, syncC_next;

	always_comb begin
		syncA_next = {carrierSyncInput, rxSerial, rxClk, txClk, busPhaseClock};
		syncB_next = syncA_reg;
		syncC_next = syncB_reg;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= 5'h00;
			syncB_reg <= 5'h00;
			syncC_reg <= 5'h00;
		end else begin
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
			syncC_reg <= syncC_next;
		end
	end

	logic phaseFall, txRise, txFall, rxRise, rxBit, carrier;
	assign phaseFall = syncC_reg[0] & ~syncB_reg[0];
	assign txRise    = ~syncC_reg[1] & syncB_reg[1];
	assign txFall    = syncC_reg[1] & ~syncB_reg[1];
	assign rxRise    = ~syncC_reg[2] & syncB_reg[2];
	assign rxBit     = syncB_reg[3];
	assign carrier   = syncB_reg[4];

	// ****************************************
	// control registers
	// ****************************************
	logic [7:0] ctrl1_reg, ctrl2_reg, syncCode_reg;
	logic [7:0] ctrl1_next, ctrl2_next, syncCode_next;
	logic       wrCtrl1, wrData, dataRead, statusRead;
	logic       rxHoldReset, txHoldReset, stripSync, clearSync, twoByte;
	logic       syncOnUnderflow;
	sst_pkg::sst_mode_e syncMode;

	assign wrCtrl1    = busWrStb && (busAddr == sst_pkg::ADDR_CTRL1);
	assign wrData     = busWrStb && (busAddr == sst_pkg::ADDR_DATA);
	assign dataRead   = busRdStb && (busAddr == sst_pkg::ADDR_DATA);
	assign statusRead = busRdStb && (busAddr == sst_pkg::ADDR_STATUS);

	assign rxHoldReset     = ctrl1_reg[sst_pkg::C1_RX_HOLD];
	assign txHoldReset     = ctrl1_reg[sst_pkg::C1_TX_HOLD];
	assign stripSync       = ctrl1_reg[sst_pkg::C1_STRIP];
	assign clearSync       = ctrl1_reg[sst_pkg::C1_CLR_SYNC];
	assign twoByte         = ctrl2_reg[sst_pkg::C2_TWO_BYTE];
	assign syncOnUnderflow = ctrl2_reg[sst_pkg::C2_SYNC_UNDF];
	assign syncMode        = sst_pkg::sst_mode_e'(ctrl2_reg[sst_pkg::C2_MODE_LO +: 2]);

	// ****************************************
	// transmit fifo and shifter
	// ****************************************
	typedef enum logic [3:0] {
		TX_HOLD  = 4'b0001,
		TX_WAIT  = 4'b0010,
		TX_ARMED = 4'b0100,
		TX_RUN   = 4'b1000
	} sst_tx_e;

	sst_tx_e    txState_reg, txState_next;
	logic [7:0] txFifo_reg [DEPTH];
	logic [7:0] txFifo_next [DEPTH];
	logic [DEPTH-1:0] txValid_reg, txValid_next;
	logic [7:0] txShift_reg, txShift_next, txPick_reg, txPick_next;
	logic [2:0] txCnt_reg, txCnt_next;
	logic       txSerial_next, txFlush_reg, txFlush_next, txPickNow;
	logic       txSpaceFlag;

	// inhibited while held so a preload cannot raise a false request
	assign txSpaceFlag = !txHoldReset && !txFlush_reg && !txValid_reg[0]
		&& (!twoByte || !txValid_reg[1]);
	assign txPickNow = (txState_reg == TX_WAIT && txRise)
		|| (txState_reg == TX_RUN && txRise && txCnt_reg == 3'(CHAR_BITS - 1));

	always_comb begin
		txState_next  = txState_reg;
		txFifo_next   = txFifo_reg;
		txValid_next  = txValid_reg;
		txShift_next  = txShift_reg;
		txPick_next   = txPick_reg;
		txCnt_next    = txCnt_reg;
		txSerial_next = txSerial;
		txFlush_next  = txFlush_reg;
		if (wrCtrl1 && busWrData[sst_pkg::C1_TX_HOLD] && !txHoldReset)
			txFlush_next = 1'b1;
		else if (phaseFall)
			txFlush_next = 1'b0;
		if (txPickNow) begin
			if (txValid_reg[DEPTH-1]) begin
				txPick_next              = txFifo_reg[DEPTH-1];
				txValid_next[DEPTH-1]    = 1'b0;
			end else begin
				txPick_next = syncOnUnderflow ? syncCode_reg : sst_pkg::FILL_ONES;
			end
		end
		if (phaseFall) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				if (!txValid_next[i] && txValid_next[i-1]) begin
					txFifo_next[i]    = txFifo_next[i-1];
					txValid_next[i]   = 1'b1;
					txValid_next[i-1] = 1'b0;
				end
			end
		end
		if (wrData && !txFlush_reg && !txValid_next[0]) begin
			txFifo_next[0]  = busWrData;
			txValid_next[0] = 1'b1;
		end
		if (txFlush_reg || txFlush_next)
			txValid_next = '0;
		case (txState_reg)
			TX_HOLD: begin
				if (!txHoldReset)
					txState_next = TX_WAIT;
			end
			TX_WAIT: begin
				if (txRise)
					txState_next = TX_ARMED;
			end
			TX_ARMED: begin
				if (txFall) begin
					txShift_next  = txPick_reg;
					txSerial_next = txPick_reg[0];
					txCnt_next    = 3'h0;
					txState_next  = TX_RUN;
				end
			end
			TX_RUN: begin
				if (txFall) begin
					if (txCnt_reg == 3'(CHAR_BITS - 1)) begin
						txShift_next  = txPick_reg;
						txSerial_next = txPick_reg[0];
						txCnt_next    = 3'h0;
					end else begin
						txCnt_next    = txCnt_reg + 3'h1;
						txSerial_next = txShift_reg[txCnt_next];
					end
				end
			end
			default: txState_next = TX_HOLD;
		endcase
		if (txHoldReset) begin
			txState_next  = TX_HOLD;
			txSerial_next = 1'b1;
			txCnt_next    = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txState_reg <= TX_HOLD;
			txFifo_reg  <= '{default: 8'h00};
			txValid_reg <= '0;
			txShift_reg <= 8'hFF;
			txPick_reg  <= 8'hFF;
			txCnt_reg   <= 3'h0;
			txSerial    <= 1'b1;
			txFlush_reg <= 1'b1;
		end else begin
			txState_reg <= txState_next;
			txFifo_reg  <= txFifo_next;
			txValid_reg <= txValid_next;
			txShift_reg <= txShift_next;
			txPick_reg  <= txPick_next;
			txCnt_reg   <= txCnt_next;
			txSerial    <= txSerial_next;
			txFlush_reg <= txFlush_next;
		end
	end

	// ****************************************
	// receive synchroniser, fifo and overrun
	// ****************************************
	typedef enum logic [2:0] {
		RX_HUNT   = 3'b001,
		RX_SECOND = 3'b010,
		RX_SYNCED = 3'b100
	} sst_rx_e;

	sst_rx_e    rxState_reg, rxState_next;
	logic [7:0] rxShift_reg, rxShift_next, rxShiftIn;
	logic [7:0] rxFifo_reg [DEPTH];
	logic [7:0] rxFifo_next [DEPTH];
	logic [DEPTH-1:0] rxValid_reg, rxValid_next;
	logic [2:0] rxCnt_reg, rxCnt_next;
	logic       overrun_reg, overrun_next, ovrSeen_reg, ovrSeen_next;
	logic       rxPush, rxLast, rxReady, ovrSet;

	assign rxShiftIn = {rxBit, rxShift_reg[7:1]};
	assign rxLast    = rxRise && rxCnt_reg == 3'(CHAR_BITS - 1);
	assign rxPush    = rxState_reg == RX_SYNCED && rxLast && !rxHoldReset
		&& !(syncMode == sst_pkg::SST_SYNC_EXT && !carrier)
		&& !(stripSync && rxShiftIn == syncCode_reg);
	assign rxReady   = rxValid_reg[DEPTH-1] && (!twoByte || rxValid_reg[DEPTH-2]);

	always_comb begin
		rxState_next = rxState_reg;
		rxShift_next = rxRise ? rxShiftIn : rxShift_reg;
		rxCnt_next   = rxRise ? rxCnt_reg + 3'h1 : rxCnt_reg;
		rxFifo_next  = rxFifo_reg;
		rxValid_next = rxValid_reg;
		case (rxState_reg)
			RX_HUNT: begin
				rxCnt_next = 3'h0;
				if (syncMode == sst_pkg::SST_SYNC_EXT) begin
					if (carrier)
						rxState_next = RX_SYNCED;
				end else if (rxRise && !clearSync && rxShiftIn == syncCode_reg) begin
					rxState_next = (syncMode == sst_pkg::SST_SYNC_TWO) ? RX_SECOND
						: RX_SYNCED;
				end
			end
			RX_SECOND: begin
				if (rxLast)
					rxState_next = (rxShiftIn == syncCode_reg) ? RX_SYNCED
						: RX_HUNT;
			end
			RX_SYNCED: begin
				if (syncMode == sst_pkg::SST_SYNC_EXT && !carrier)
					rxState_next = RX_HUNT;
			end
			default: rxState_next = RX_HUNT;
		endcase
		if (clearSync)
			rxState_next = RX_HUNT;
		if (dataRead)
			rxValid_next[DEPTH-1] = 1'b0;
		if (phaseFall) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				if (!rxValid_next[i] && rxValid_next[i-1]) begin
					rxFifo_next[i]    = rxFifo_next[i-1];
					rxValid_next[i]   = 1'b1;
					rxValid_next[i-1] = 1'b0;
				end
			end
		end
		ovrSet = rxPush && rxValid_next[0];
		if (rxPush) begin
			rxFifo_next[0]  = rxShiftIn;
			rxValid_next[0] = 1'b1;
		end
		if (rxHoldReset) begin
			rxState_next = RX_HUNT;
			rxShift_next = sst_pkg::RX_IDLE;
			rxCnt_next   = 3'h0;
			rxValid_next = '0;
		end
		// a fresh overrun beats the pending clear
		if (ovrSet) begin
			overrun_next = 1'b1;
			ovrSeen_next = 1'b0;
		end else if (ovrSeen_reg && dataRead) begin
			overrun_next = 1'b0;
			ovrSeen_next = 1'b0;
		end else begin
			overrun_next = overrun_reg;
			ovrSeen_next = ovrSeen_reg || (statusRead && overrun_reg);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxState_reg <= RX_HUNT;
			rxShift_reg <= sst_pkg::RX_IDLE;
			rxCnt_reg   <= 3'h0;
			rxFifo_reg  <= '{default: 8'h00};
			rxValid_reg <= '0;
			overrun_reg <= 1'b0;
			ovrSeen_reg <= 1'b0;
		end else begin
			rxState_reg <= rxState_next;
			rxShift_reg <= rxShift_next;
			rxCnt_reg   <= rxCnt_next;
			rxFifo_reg  <= rxFifo_next;
			rxValid_reg <= rxValid_next;
			overrun_reg <= overrun_next;
			ovrSeen_reg <= ovrSeen_next;
		end
	end

	// ****************************************
	// register port and interrupt
	// ****************************************
	sst_pkg::sst_status_s status;
	logic [7:0] busRdData_next;
	logic       irqOe_next, irqReq;

	assign irqReq = (ctrl1_reg[sst_pkg::C1_RX_IRQ_EN] && rxReady)
		|| (ctrl2_reg[sst_pkg::C2_ERR_IRQ] && overrun_reg)
		|| (ctrl1_reg[sst_pkg::C1_TX_IRQ_EN] && txSpaceFlag);

	always_comb begin
		status         = '0;
		status.rxReady = rxReady;
		status.txSpace = txSpaceFlag;
		status.overrun = overrun_reg;
		status.carrier = carrier;
		status.synced  = rxState_reg == RX_SYNCED;
		status.irqActive = irqOe;
		ctrl1_next     = ctrl1_reg;
		ctrl2_next     = ctrl2_reg;
		syncCode_next  = syncCode_reg;
		busRdData_next = 8'h00;
		irqOe_next     = irqReq;
		if (busWrStb) begin
			case (busAddr)
				sst_pkg::ADDR_CTRL1: ctrl1_next    = busWrData;
				sst_pkg::ADDR_CTRL2: ctrl2_next    = busWrData;
				sst_pkg::ADDR_SYNC:  syncCode_next = busWrData;
				default: ;
			endcase
		end
		if (busRdStb) begin
			case (busAddr)
				sst_pkg::ADDR_CTRL1:  busRdData_next = ctrl1_reg;
				sst_pkg::ADDR_CTRL2:  busRdData_next = ctrl2_reg;
				sst_pkg::ADDR_SYNC:   busRdData_next = syncCode_reg;
				sst_pkg::ADDR_DATA:   busRdData_next = rxFifo_reg[DEPTH-1];
				sst_pkg::ADDR_STATUS: busRdData_next = status;
				default:              busRdData_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl1_reg    <= sst_pkg::CTRL1_RST;
			ctrl2_reg    <= sst_pkg::CTRL2_RST;
			syncCode_reg <= sst_pkg::SYNC_RST;
			busRdData    <= 8'h00;
			irqOe        <= 1'b0;
			irqOut       <= 1'b0;
		end else begin
			ctrl1_reg    <= ctrl1_next;
			ctrl2_reg    <= ctrl2_next;
			syncCode_reg <= syncCode_next;
			busRdData    <= busRdData_next;
			irqOe        <= irqOe_next;
			irqOut       <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_ovrShown;
		statusRead && overrun_reg && !ovrSet;
	endsequence
	sequence s_dataTaken;
		dataRead && !ovrSet;
	endsequence

	a_rx_idle_high: assert property (rxHoldReset |=> rxShift_reg == 8'hFF)
		else $error("receive shifter not all ones in reset");
	a_ovr_set: assert property (ovrSet |=> overrun_reg)
		else $error("overrun not set on full input location");
	a_ovr_needs_status: assert property (overrun_reg && !ovrSeen_reg && !statusRead |=> overrun_reg)
		else $error("overrun cleared without status read");
	a_ovr_clear_seq: assert property (s_ovrShown ##1 !ovrSet ##1 s_dataTaken |=> !overrun_reg)
		else $error("overrun not cleared after status then data read");
	a_tx_hold_flag: assert property (txHoldReset |-> !txSpaceFlag)
		else $error("space flag raised while held");
	a_tx_flush: assert property ($rose(txHoldReset) |-> txValid_reg == '0)
		else $error("transmit fifo not emptied on hold");
	a_rdy_two: assert property (twoByte && !rxValid_reg[1] |-> !rxReady)
		else $error("ready raised with one byte in two-byte mode");
	a_irq_rx: assert property (ctrl1_reg[sst_pkg::C1_RX_IRQ_EN] && rxReady |=> irqOe)
		else $error("receive interrupt missing");
	a_fill_char: assert property (txPickNow && !txValid_reg[DEPTH-1] |=>
		txPick_reg == (syncOnUnderflow ? syncCode_reg : 8'hFF))
		else $error("wrong underflow fill character");
	a_no_sync_store: assert property (rxState_reg != RX_SYNCED |-> !rxPush)
		else $error("character stored before sync");
	a_lsb_first: assert property (txState_reg == TX_ARMED && txFall |=> txSerial == txShift_reg[0])
		else $error("first bit is not the least significant");

endmodule : sst_core

// ===== tb/sst_link_peer.sv
// link peer: drives both link clocks and receive data, captures transmit data
module sst_link_peer (
	output logic      txClk,
	output logic      rxClk,
	output logic      rxSerial,
	input  wire logic txSerial
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] txByteQ[$];

	initial begin
		txClk    = 1'b0;
		rxClk    = 1'b0;
		rxSerial = 1'b1;
	end

	// 80 ns clock only inside frames, stands low between them;
	// each bit is taken 60 ns after the fall that launched it
	task automatic tx_frames(input int n);
		logic [7:0] b;
		b = 8'h00;
		#3;
		for (int i = 0; i <= n * 8; i++) begin
			if (i < n * 8) begin
				txClk = 1'b1;
			end
			#20;
			if (i > 0) begin
				b = {txSerial, b[7:1]};
				if (i % 8 == 0) begin
					txByteQ.push_back(b);
				end
			end
			if (i < n * 8) begin
				#20;
				txClk = 1'b0;
				#40;
			end
		end
	endtask : tx_frames

	// data settles a half period before the sampling rise
	task automatic send_bit(input logic v);
		rxSerial = v;
		#40;
		rxClk = 1'b1;
		#40;
		rxClk = 1'b0;
	endtask : send_bit

	// data line flips once while the clock stands, so no stale level is trusted
	task automatic pause_link();
		rxSerial = ~rxSerial;
		#3000;
	endtask : pause_link
endmodule : sst_link_peer

// ===== tb/sst_core_tb_top.sv
// testbench: bus tasks, receive model and scenarios for the serial core
module sst_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// signals
	// ****************************************
	logic                 clk;
	logic                 arst_n;
	logic [2:0]           busAddr;
	logic [7:0]           busWrData;
	logic                 busWrStb;
	logic                 busRdStb;
	logic [7:0]           busRdData;
	logic                 busPhaseClock;
	logic                 txClk;
	logic                 rxClk;
	logic                 rxSerial;
	logic                 carrierSyncInput;
	logic                 txSerial;
	logic                 irqOut;
	logic                 irqOe;
	logic [7:0]           rdVal;
	logic [7:0]           syncCode;
	logic [7:0]           b0;
	logic [7:0]           b1;
	logic [7:0]           expQ[$];
	logic [7:0]           dataQ[$];
	logic                 bitQ[$];
	logic                 expOvr;
	sst_pkg::sst_status_s stat;
	int                   miscompares = 0;
	int                   totalChecks = 0;
	int                   cycles      = 0;
	int                   phaseCnt    = 0;
	int                   seed        = 43;

	sst_core #(.CHAR_BITS(8), .DEPTH(3)) dut_u (
		.clk(clk), .arst_n(arst_n), .busAddr(busAddr), .busWrData(busWrData),
		.busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
		.busPhaseClock(busPhaseClock), .txClk(txClk), .rxClk(rxClk),
		.rxSerial(rxSerial), .carrierSyncInput(carrierSyncInput),
		.txSerial(txSerial), .irqOut(irqOut), .irqOe(irqOe)
	);

	sst_link_peer peer_u (.txClk(txClk), .rxClk(rxClk), .rxSerial(rxSerial), .txSerial(txSerial));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// bus phase clock at 1 MHz, 100 system cycles
	always @(posedge clk) begin
		phaseCnt      <= (phaseCnt == 99) ? 0 : phaseCnt + 1;
		busPhaseClock <= (phaseCnt < 50);
	end

	// whole run needs about 12500 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares++;
			end_sim();
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_clk

	// an idle cycle after each write keeps the strobe edges apart
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		busAddr   <= a;
		busWrData <= d;
		busWrStb  <= 1'b1;
		@(posedge clk);
		busWrStb  <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [2:0] a);
		busAddr  <= a;
		busRdStb <= 1'b1;
		@(posedge clk);
		busRdStb <= 1'b0;
		@(posedge clk);
		rdVal = busRdData;
		stat  = busRdData;
	endtask : rd

	// receive model: bit hunt, sync states, strip, three-deep fifo with overwrite
	task automatic model_rx(input sst_pkg::sst_mode_e mode, input logic strip);
		logic [7:0] sh;
		int st;
		int cnt;
		sh     = sst_pkg::RX_IDLE;
		st     = (mode == sst_pkg::SST_SYNC_EXT) ? 2 : 0;
		cnt    = 0;
		expOvr = 1'b0;
		expQ.delete();
		foreach (bitQ[i]) begin
			sh = {bitQ[i], sh[7:1]};
			cnt++;
			if (st == 0 && sh == syncCode) begin
				st  = (mode == sst_pkg::SST_SYNC_ONE) ? 2 : 1;
				cnt = 0;
			end else if (st != 0 && cnt == 8) begin
				cnt = 0;
				if (st == 1) begin
					st = (sh == syncCode) ? 2 : 0;
				end else if (!(strip && sh == syncCode)) begin
					if (expQ.size() == 3) begin
						void'(expQ.pop_back());
						expOvr = 1'b1;
					end
					expQ.push_back(sh);
				end
			end
		end
	endtask : model_rx

	task automatic rx_run(input sst_pkg::sst_mode_e mode, input logic strip, input logic two,
		input int lead);
		logic rdyExp;
		wr(sst_pkg::ADDR_CTRL1, 8'h0B);
		rd(sst_pkg::ADDR_STATUS);
		chk_bit(stat.synced, 1'b0);
		wr(sst_pkg::ADDR_CTRL2, {3'h0, mode, 2'h1, two});
		wr(sst_pkg::ADDR_SYNC, syncCode);
		wr(sst_pkg::ADDR_CTRL1, {5'h04, strip, 2'h2});
		carrierSyncInput <= (mode == sst_pkg::SST_SYNC_EXT);
		wait_clk(4);
		bitQ.delete();
		repeat (lead) bitQ.push_back(1'b0);
		foreach (dataQ[i]) for (int k = 0; k < 8; k++) bitQ.push_back(dataQ[i][k]);
		model_rx(mode, strip);
		// keep link edges off the system clock edge
		#3;
		foreach (bitQ[i]) begin
			peer_u.send_bit(bitQ[i]);
			if (i % 8 == 7) peer_u.pause_link();
		end
		wait_clk(400);
		rd(sst_pkg::ADDR_DATA);
		chk_byte(rdVal, expQ.pop_front());
		wait_clk(400);
		rd(sst_pkg::ADDR_STATUS);
		rdyExp = two ? (expQ.size() > 1) : (expQ.size() > 0);
		chk_bit(stat.rxReady, rdyExp);
		chk_bit(stat.overrun, expOvr);
		chk_bit(stat.synced, 1'b1);
		chk_bit(irqOe, rdyExp || expOvr);
		if (expQ.size() > 0) expOvr = 1'b0;
		while (expQ.size() > 0) begin
			rd(sst_pkg::ADDR_DATA);
			chk_byte(rdVal, expQ.pop_front());
			wait_clk(400);
		end
		rd(sst_pkg::ADDR_STATUS);
		chk_bit(stat.rxReady, 1'b0);
		chk_bit(stat.overrun, expOvr);
		carrierSyncInput <= 1'b0;
		$display("test receive mode %0d done", mode);
	endtask : rx_run

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		arst_n           = 1'b0;
		busAddr          = 3'h0;
		busWrData        = 8'h00;
		busWrStb         = 1'b0;
		busRdStb         = 1'b0;
		carrierSyncInput = 1'b0;
		syncCode         = 8'h7E;
		wait_clk(12);
		arst_n <= 1'b1;
		wait_clk(1);
		rd(sst_pkg::ADDR_CTRL1);
		chk_byte(rdVal, sst_pkg::CTRL1_RST);
		rd(sst_pkg::ADDR_CTRL2);
		chk_byte(rdVal, sst_pkg::CTRL2_RST);
		rd(sst_pkg::ADDR_SYNC);
		chk_byte(rdVal, sst_pkg::SYNC_RST);
		rd(3'h7);
		chk_byte(rdVal, 8'h00);
		rd(sst_pkg::ADDR_STATUS);
		chk_bit(stat.txSpace, 1'b0);
		chk_bit(txSerial, 1'b1);
		chk_bit(irqOut, 1'b0);
		$display("test reset done");
		wr(sst_pkg::ADDR_CTRL1, 8'h01);
		peer_u.tx_frames(1);
		chk_byte(peer_u.txByteQ.pop_front(), sst_pkg::FILL_ONES);
		wait_clk(1);
		wr(sst_pkg::ADDR_DATA, 8'h3C);
		wr(sst_pkg::ADDR_CTRL1, 8'h03);
		wait_clk(200);
		b0 = 8'($random(seed));
		b1 = 8'($random(seed));
		wr(sst_pkg::ADDR_DATA, b0);
		wait_clk(200);
		wr(sst_pkg::ADDR_DATA, b1);
		wait_clk(200);
		rd(sst_pkg::ADDR_STATUS);
		chk_bit(stat.txSpace, 1'b0);
		wr(sst_pkg::ADDR_SYNC, syncCode);
		wr(sst_pkg::ADDR_CTRL2, 8'h04);
		wr(sst_pkg::ADDR_CTRL1, 8'h01);
		repeat (3) begin
			peer_u.tx_frames(1);
			// clock stands between frames so the fifo can step to its output
			wait_clk(200);
		end
		chk_byte(peer_u.txByteQ.pop_front(), b0);
		chk_byte(peer_u.txByteQ.pop_front(), b1);
		chk_byte(peer_u.txByteQ.pop_front(), syncCode);
		wait_clk(300);
		rd(sst_pkg::ADDR_STATUS);
		chk_bit(stat.txSpace, 1'b1);
		wr(sst_pkg::ADDR_CTRL1, 8'h11);
		wait_clk(2);
		chk_bit(irqOe, 1'b1);
		$display("test transmit done");
		b0 = 8'($random(seed)) & 8'h3F;
		b1 = 8'($random(seed)) & 8'h3F;
		// data kept below 8'h40 so it never equals the sync code
		dataQ = '{syncCode, syncCode, b0, syncCode, b1};
		rx_run(sst_pkg::SST_SYNC_ONE, 1'b1, 1'b0, 1 + ($random(seed) & 3));
		dataQ = '{syncCode, 8'h00, syncCode, syncCode, b1, b0, b1};
		rx_run(sst_pkg::SST_SYNC_TWO, 1'b0, 1'b1, 1 + ($random(seed) & 3));
		dataQ = '{b0, syncCode, b1, b0, b1 ^ 8'h11};
		rx_run(sst_pkg::SST_SYNC_EXT, 1'b0, 1'b0, 0);
		end_sim();
	end
endmodule : sst_core_tb_top
